// [hdl/feedback_sel_pkg.sv]
// constants and types shared by the feedback source selector
package feedback_sel_pkg;

    // ---------------------------------------------------------------
    // object dictionary indices and subindices
    // ---------------------------------------------------------------
    localparam logic [15:0] SEL_INDEX = 16'h3203;
    localparam logic [15:0] MAP_INDEX = 16'h3204;
    localparam logic [15:0] INERTIA_INDEX = 16'h320d;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_ENTRY1 = 8'h01;
    localparam logic [7:0] SUB_ENTRY2 = 8'h02;
    localparam logic [7:0] SUB_ENTRY3 = 8'h03;

    // ---------------------------------------------------------------
    // reset and read-only values
    // ---------------------------------------------------------------
    localparam logic [7:0] FB_COUNT = 8'h03;
    localparam logic [7:0] INERTIA_COUNT = 8'h02;
    localparam logic [15:0] MAP_ENTRY1 = 16'h3380;
    localparam logic [15:0] MAP_ENTRY2 = 16'h3390;
    localparam logic [15:0] MAP_ENTRY3 = 16'h33a0;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [31:0] INERTIA_RESET = 32'h0000_0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int BIT_POS = 0;
    localparam int BIT_VEL = 1;
    localparam int BIT_COMM = 2;
    localparam int LOOP_CLOSED_BIT = 0;
    localparam int MASK_W = 8;
    localparam int SUBMODE_W = 32;

    // ---------------------------------------------------------------
    // feedback numbers
    // ---------------------------------------------------------------
    localparam logic [1:0] FB_SENSORLESS = 2'h1;
    localparam logic [1:0] FB_SECOND = 2'h2;
    localparam logic [1:0] FB_THIRD = 2'h3;

    typedef enum logic [3:0] {
        obj_none,
        obj_sel_count,
        obj_mask1,
        obj_mask2,
        obj_mask3,
        obj_map_count,
        obj_map1,
        obj_map2,
        obj_map3,
        obj_inertia_count,
        obj_current,
        obj_accel
    } obj_sel_t;

    typedef enum {
        st_disabled,
        st_enabled
    } op_state_t;

endpackage

// [hdl/feedback_source_selector.sv]
// feedback source selector with its object dictionary entries
`timescale 1ns/1ns

// How it works
// RQ1: mask writes during operation enabled wait until the next entry into that state; the code applies them as soon as operation enabled is left.
// RQ2: selection subindex zero reads the feedback count, three.
// RQ3: mask bit 0 makes a sensor a position feedback candidate.
// RQ4: mask bit 1 makes a sensor a velocity feedback candidate.
// RQ5: mask bit 2 makes a sensor a closed loop commutation candidate.
// RQ6: entry one is always the sensorless feedback; others follow fixed order.
// RQ7: each role scans from sensor 2 upward through every existing sensor.
// RQ8: first sensor with its bit set wins; scanning for that role stops.
// RQ9: in open loop the commutation bit of every mask is ignored.
// RQ10: open loop still picks position and velocity sources from their bits.
// RQ11: mapping entries read 3380h, 3390h and 33a0h for feedbacks one to three.
// RQ12: a zero inertia factor disables acceleration feed forward; zero after reset.
// RQ13: a nonzero factor enables feed forward for deceleration and acceleration alike.
// RQ14: master writes calibration current in milliamperes into inertia subindex one.
// RQ15: master writes measured constant-rate acceleration into inertia subindex two.
// RQ16: loop closure select is submode bit 0; one closed, zero open.
// RQ17: mask bits above bit 2 are stored but never affect selection.
module feedback_source_selector (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [15:0] obj_index_i,
    input wire logic [7:0] obj_subindex_i,
    input wire logic obj_rd_i,
    input wire logic obj_wr_i,
    input wire logic [31:0] obj_wdata_i,
    output logic [31:0] obj_rdata_o,
    output logic obj_ack_o,
    output logic obj_err_o,
    input wire logic op_enabled_i,
    input wire logic [31:0] submode_ctrl_i,
    output logic [1:0] pos_src_o,
    output logic pos_found_o,
    output logic [1:0] vel_src_o,
    output logic vel_found_o,
    output logic [1:0] comm_src_o,
    output logic comm_found_o,
    output logic accel_ff_en_o,
    output logic [31:0] inertia_current_o,
    output logic [31:0] inertia_accel_o
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic feedback_sel_pkg::obj_sel_t decode(input logic [15:0] idx,
                                                          input logic [7:0] sub);
        feedback_sel_pkg::obj_sel_t sel;
        sel = feedback_sel_pkg::obj_none;
        if (idx == feedback_sel_pkg::SEL_INDEX) begin
            case (sub)
                feedback_sel_pkg::SUB_COUNT: sel = feedback_sel_pkg::obj_sel_count;
                feedback_sel_pkg::SUB_ENTRY1: sel = feedback_sel_pkg::obj_mask1;
                feedback_sel_pkg::SUB_ENTRY2: sel = feedback_sel_pkg::obj_mask2;
                feedback_sel_pkg::SUB_ENTRY3: sel = feedback_sel_pkg::obj_mask3;
                default: sel = feedback_sel_pkg::obj_none;
            endcase
        end else if (idx == feedback_sel_pkg::MAP_INDEX) begin
            case (sub)
                feedback_sel_pkg::SUB_COUNT: sel = feedback_sel_pkg::obj_map_count;
                feedback_sel_pkg::SUB_ENTRY1: sel = feedback_sel_pkg::obj_map1;
                feedback_sel_pkg::SUB_ENTRY2: sel = feedback_sel_pkg::obj_map2;
                feedback_sel_pkg::SUB_ENTRY3: sel = feedback_sel_pkg::obj_map3;
                default: sel = feedback_sel_pkg::obj_none;
            endcase
        end else if (idx == feedback_sel_pkg::INERTIA_INDEX) begin
            case (sub)
                feedback_sel_pkg::SUB_COUNT: sel = feedback_sel_pkg::obj_inertia_count;
                feedback_sel_pkg::SUB_ENTRY1: sel = feedback_sel_pkg::obj_current;
                feedback_sel_pkg::SUB_ENTRY2: sel = feedback_sel_pkg::obj_accel;
                default: sel = feedback_sel_pkg::obj_none;
            endcase
        end
        return sel;
    endfunction

    // sensor 1 is sensorless and never scanned; it is the fallback only
    function automatic logic [2:0] first_src(input logic [7:0] m2,
                                             input logic [7:0] m3,
                                             input int b);
        logic [2:0] res;
        res = {1'b0, feedback_sel_pkg::FB_SENSORLESS};
        if (m2[b]) begin // [RQ7] [RQ8]
            res = {1'b1, feedback_sel_pkg::FB_SECOND};
        end else if (m3[b]) begin
            res = {1'b1, feedback_sel_pkg::FB_THIRD};
        end
        return res;
    endfunction

    // ---------------------------------------------------------------
    // drive state tracking
    // ---------------------------------------------------------------
    feedback_sel_pkg::op_state_t op_state_reg;
    logic op_enter;
    assign op_enter = (op_state_reg == feedback_sel_pkg::st_disabled) && op_enabled_i;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_state_reg <= feedback_sel_pkg::st_disabled;
        end else begin
            case (op_state_reg)
                feedback_sel_pkg::st_disabled: begin
                    if (op_enabled_i) begin
                        op_state_reg <= feedback_sel_pkg::st_enabled;
                    end
                end
                feedback_sel_pkg::st_enabled: begin
                    if (!op_enabled_i) begin
                        op_state_reg <= feedback_sel_pkg::st_disabled;
                    end
                end
                default: op_state_reg <= feedback_sel_pkg::st_disabled;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // object access
    // ---------------------------------------------------------------
    feedback_sel_pkg::obj_sel_t acc_sel;
    logic [7:0] mask_reg [0:2];
    logic [7:0] active_reg [0:2];
    logic [31:0] current_reg;
    logic [31:0] accel_reg;
    logic [31:0] rdata_next;
    logic acc_ro;

    assign acc_sel = decode(obj_index_i, obj_subindex_i);
    assign acc_ro = !(acc_sel inside {feedback_sel_pkg::obj_mask1, feedback_sel_pkg::obj_mask2,
                                      feedback_sel_pkg::obj_mask3, feedback_sel_pkg::obj_current,
                                      feedback_sel_pkg::obj_accel});

    always_comb begin
        rdata_next = feedback_sel_pkg::RDATA_RESET;
        case (acc_sel)
            feedback_sel_pkg::obj_sel_count: rdata_next[7:0] = feedback_sel_pkg::FB_COUNT; // [RQ2]
            feedback_sel_pkg::obj_mask1: rdata_next[7:0] = mask_reg[0];
            feedback_sel_pkg::obj_mask2: rdata_next[7:0] = mask_reg[1];
            feedback_sel_pkg::obj_mask3: rdata_next[7:0] = mask_reg[2];
            feedback_sel_pkg::obj_map_count: rdata_next[7:0] = feedback_sel_pkg::FB_COUNT;
            feedback_sel_pkg::obj_map1: rdata_next[15:0] = feedback_sel_pkg::MAP_ENTRY1; // [RQ6] [RQ11]
            feedback_sel_pkg::obj_map2: rdata_next[15:0] = feedback_sel_pkg::MAP_ENTRY2; // [RQ11]
            feedback_sel_pkg::obj_map3: rdata_next[15:0] = feedback_sel_pkg::MAP_ENTRY3; // [RQ11]
            feedback_sel_pkg::obj_inertia_count: rdata_next[7:0] = feedback_sel_pkg::INERTIA_COUNT;
            feedback_sel_pkg::obj_current: rdata_next = current_reg;
            feedback_sel_pkg::obj_accel: rdata_next = accel_reg;
            default: rdata_next = feedback_sel_pkg::RDATA_RESET;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            obj_ack_o <= 1'b0;
            obj_err_o <= 1'b0;
            obj_rdata_o <= feedback_sel_pkg::RDATA_RESET;
        end else begin
            obj_ack_o <= obj_rd_i || obj_wr_i;
            obj_err_o <= (obj_rd_i || obj_wr_i) && (acc_sel == feedback_sel_pkg::obj_none ||
                                                   (obj_wr_i && acc_ro));
            if (obj_rd_i && !obj_wr_i) begin
                obj_rdata_o <= rdata_next;
            end
        end
    end

    // full byte kept so upper bits read back, selection looks at bits 2..0 only
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 3; i++) begin
                mask_reg[i] <= feedback_sel_pkg::MASK_RESET;
            end
        end else if (obj_wr_i) begin
            case (acc_sel)
                feedback_sel_pkg::obj_mask1: mask_reg[0] <= obj_wdata_i[7:0]; // [RQ17]
                feedback_sel_pkg::obj_mask2: mask_reg[1] <= obj_wdata_i[7:0];
                feedback_sel_pkg::obj_mask3: mask_reg[2] <= obj_wdata_i[7:0];
                default: mask_reg[0] <= mask_reg[0];
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            current_reg <= feedback_sel_pkg::INERTIA_RESET; // [RQ12]
            accel_reg <= feedback_sel_pkg::INERTIA_RESET;
        end else if (obj_wr_i) begin
            if (acc_sel == feedback_sel_pkg::obj_current) begin
                current_reg <= obj_wdata_i; // [RQ14]
            end
            if (acc_sel == feedback_sel_pkg::obj_accel) begin
                accel_reg <= obj_wdata_i; // [RQ15]
            end
        end
    end

    // ---------------------------------------------------------------
    // buffered masks
    // ---------------------------------------------------------------
    // frozen while enabled so a running controller never switches sensors mid-move
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 3; i++) begin
                active_reg[i] <= feedback_sel_pkg::MASK_RESET;
            end
        end else if (op_enter || !op_enabled_i) begin
            for (int i = 0; i < 3; i++) begin
                active_reg[i] <= mask_reg[i]; // [RQ1]
            end
        end
    end

    // ---------------------------------------------------------------
    // source selection
    // ---------------------------------------------------------------
    logic loop_closure_select;
    logic [2:0] pos_pick;
    logic [2:0] vel_pick;
    logic [2:0] comm_pick;

    assign loop_closure_select = submode_ctrl_i[feedback_sel_pkg::LOOP_CLOSED_BIT]; // [RQ16]
    assign pos_pick = first_src(active_reg[1], active_reg[2], feedback_sel_pkg::BIT_POS); // [RQ3]
    assign vel_pick = first_src(active_reg[1], active_reg[2], feedback_sel_pkg::BIT_VEL); // [RQ4]
    assign comm_pick = first_src(active_reg[1], active_reg[2], feedback_sel_pkg::BIT_COMM); // [RQ5]

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_found_o <= 1'b0;
            pos_src_o <= feedback_sel_pkg::FB_SENSORLESS;
            vel_found_o <= 1'b0;
            vel_src_o <= feedback_sel_pkg::FB_SENSORLESS;
            comm_found_o <= 1'b0;
            comm_src_o <= feedback_sel_pkg::FB_SENSORLESS;
        end else begin
            {pos_found_o, pos_src_o} <= pos_pick; // [RQ10]
            {vel_found_o, vel_src_o} <= vel_pick; // [RQ10]
            if (loop_closure_select) begin
                {comm_found_o, comm_src_o} <= comm_pick;
            end else begin
                comm_found_o <= 1'b0; // [RQ9]
                comm_src_o <= feedback_sel_pkg::FB_SENSORLESS;
            end
        end
    end

    // ---------------------------------------------------------------
    // inertia factor
    // ---------------------------------------------------------------
    // no direction input: the enable covers both acceleration and deceleration
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            accel_ff_en_o <= 1'b0;
        end else begin
            accel_ff_en_o <= (current_reg != feedback_sel_pkg::INERTIA_RESET); // [RQ12] [RQ13]
        end
    end

    assign inertia_current_o = current_reg;
    assign inertia_accel_o = accel_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_buffer_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RQ1]
        (op_state_reg == feedback_sel_pkg::st_enabled && op_enabled_i) |=>
        $stable(active_reg[1]) && $stable(active_reg[2]))
        else $error("active masks changed while operation enabled");

    a_count_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RQ2]
        (obj_rd_i && !obj_wr_i && obj_index_i == feedback_sel_pkg::SEL_INDEX &&
         obj_subindex_i == feedback_sel_pkg::SUB_COUNT) |=>
        obj_ack_o && obj_rdata_o == 32'h0000_0003)
        else $error("selection count read wrong");

    a_pos_first: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RQ3]
        active_reg[1][feedback_sel_pkg::BIT_POS] |=>
        pos_found_o && pos_src_o == feedback_sel_pkg::FB_SECOND)
        else $error("position source not sensor 2");

    a_vel_third: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RQ8]
        (!active_reg[1][feedback_sel_pkg::BIT_VEL] && active_reg[2][feedback_sel_pkg::BIT_VEL])
        |=> vel_found_o && vel_src_o == feedback_sel_pkg::FB_THIRD)
        else $error("velocity source not sensor 3");

    a_comm_open: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RQ9]
        !submode_ctrl_i[0] |=> !comm_found_o)
        else $error("commutation chosen in open loop");

    a_comm_closed: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RQ5]
        (submode_ctrl_i[0] && active_reg[1][feedback_sel_pkg::BIT_COMM]) |=>
        comm_found_o && comm_src_o == feedback_sel_pkg::FB_SECOND)
        else $error("commutation source missed");

    a_open_pos: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RQ10]
        (!submode_ctrl_i[0] && active_reg[2][feedback_sel_pkg::BIT_POS]) |=> pos_found_o)
        else $error("position lost in open loop");

    a_upper_bits: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RQ17]
        (active_reg[1][2:0] == 3'h0 && active_reg[2][2:0] == 3'h0) |=>
        !pos_found_o && !vel_found_o && !comm_found_o)
        else $error("upper mask bits affected selection");

    a_map_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RQ11]
        (obj_rd_i && !obj_wr_i && obj_index_i == feedback_sel_pkg::MAP_INDEX &&
         obj_subindex_i == feedback_sel_pkg::SUB_ENTRY3) |=> obj_rdata_o == 32'h0000_33a0)
        else $error("third mapping entry wrong");

    a_ff_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RQ12]
        (current_reg == 32'h0) |=> !accel_ff_en_o)
        else $error("feed forward on with zero factor");

endmodule

// [test/obj_master.sv]
// fieldbus master model issuing object dictionary accesses to the selector
`timescale 1ns/1ns
module obj_master (
    input wire logic clk_sys_i,
    output logic [15:0] obj_index_o,
    output logic [7:0] obj_subindex_o,
    output logic obj_rd_o,
    output logic obj_wr_o,
    output logic [31:0] obj_wdata_o,
    input wire logic [31:0] obj_rdata_i,
    input wire logic obj_ack_i,
    input wire logic obj_err_i
);
    initial begin
        obj_index_o = 16'h0000;
        obj_subindex_o = 8'h00;
        obj_rd_o = 1'b0;
        obj_wr_o = 1'b0;
        obj_wdata_o = 32'h0000_0000;
    end

    // ---------------------------------------------------------------
    // single access
    // ---------------------------------------------------------------
    // strobe is one cycle; fields stand until the answer is sampled at the next edge
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [31:0] wd, output logic [31:0] rdat,
                          output logic ack, output logic err);
        @(posedge clk_sys_i);
        obj_index_o <= idx;
        obj_subindex_o <= sub;
        obj_wdata_o <= wd;
        obj_rd_o <= ~wr;
        obj_wr_o <= wr;
        @(posedge clk_sys_i);
        obj_rd_o <= 1'b0;
        obj_wr_o <= 1'b0;
        // a held strobe would be a second access, so only the strobe drops here
        @(posedge clk_sys_i);
        rdat = obj_rdata_i;
        ack = obj_ack_i;
        err = obj_err_i;
        // released fields wander so a stale value is never mistaken for a held one
        obj_index_o <= ~idx;
        obj_subindex_o <= ~sub;
        obj_wdata_o <= ~wd;
    endtask

    // ---------------------------------------------------------------
    // inertia calibration
    // ---------------------------------------------------------------
    task automatic calibrate(input logic [31:0] cur_ma, input logic [31:0] accel);
        logic [31:0] d;
        logic a;
        logic e;
        access(1'b1, feedback_sel_pkg::INERTIA_INDEX, 8'h01, cur_ma, d, a, e);
        access(1'b1, feedback_sel_pkg::INERTIA_INDEX, 8'h02, accel, d, a, e);
    endtask
endmodule

// [test/feedback_source_selector_tb.sv]
// self-checking bench for the feedback source selector
`timescale 1ns/1ns
module feedback_source_selector_tb;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic op_enabled_i = 1'b0;
    logic [31:0] submode_ctrl_i = 32'h0000_0000;
    logic [15:0] obj_index;
    logic [7:0] obj_subindex;
    logic obj_rd;
    logic obj_wr;
    logic [31:0] obj_wdata;
    logic [31:0] obj_rdata;
    logic obj_ack;
    logic obj_err;
    logic [1:0] pos_src, vel_src, comm_src;
    logic pos_found, vel_found, comm_found, accel_ff_en;
    logic [31:0] inertia_current, inertia_accel;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int smask[1:3];
    int amask[1:3];
    int cur = 0;
    int acc_val = 0;
    logic [31:0] rdv;
    logic ackv, errv;

    always #25 clk_sys_i = ~clk_sys_i;

    feedback_source_selector DUT (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .obj_index_i(obj_index),
        .obj_subindex_i(obj_subindex), .obj_rd_i(obj_rd), .obj_wr_i(obj_wr),
        .obj_wdata_i(obj_wdata), .obj_rdata_o(obj_rdata), .obj_ack_o(obj_ack),
        .obj_err_o(obj_err), .op_enabled_i(op_enabled_i), .submode_ctrl_i(submode_ctrl_i),
        .pos_src_o(pos_src), .pos_found_o(pos_found), .vel_src_o(vel_src),
        .vel_found_o(vel_found), .comm_src_o(comm_src), .comm_found_o(comm_found),
        .accel_ff_en_o(accel_ff_en), .inertia_current_o(inertia_current),
        .inertia_accel_o(inertia_accel));

    obj_master master (
        .clk_sys_i(clk_sys_i), .obj_index_o(obj_index), .obj_subindex_o(obj_subindex),
        .obj_rd_o(obj_rd), .obj_wr_o(obj_wr), .obj_wdata_o(obj_wdata),
        .obj_rdata_i(obj_rdata), .obj_ack_i(obj_ack), .obj_err_i(obj_err));

    // ---------------------------------------------------------------
    // checking helpers
    // ---------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // generous: the whole sequence needs well under 2000 cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] wd, input logic [31:0] exp, input logic experr);
        master.access(wr, idx, sub, wd, rdv, ackv, errv);
        chk({31'h0, ackv}, 32'h1);
        chk({31'h0, errv}, {31'h0, experr});
        if (!wr) begin
            chk(rdv, exp);
        end
        if (wr && !experr && idx == feedback_sel_pkg::SEL_INDEX) begin
            smask[sub] = int'(wd[7:0]);
        end
    endtask

    // scan order fixed: sensor 2 first, sensor 1 never a candidate
    function automatic logic [2:0] pick(input int b, input logic en);
        for (int i = 2; i <= 3; i++) begin
            if (en && amask[i][b]) begin
                return {1'b1, 2'(i)};
            end
        end
        return {1'b0, feedback_sel_pkg::FB_SENSORLESS};
    endfunction

    task automatic check_sel();
        logic [2:0] e;
        repeat (3) @(posedge clk_sys_i);
        #1;
        if (!op_enabled_i) begin
            amask = smask;
        end
        e = pick(feedback_sel_pkg::BIT_POS, 1'b1);
        chk({29'h0, pos_found, pos_src}, {29'h0, e});
        e = pick(feedback_sel_pkg::BIT_VEL, 1'b1);
        chk({29'h0, vel_found, vel_src}, {29'h0, e});
        e = pick(feedback_sel_pkg::BIT_COMM, submode_ctrl_i[0]);
        chk({29'h0, comm_found, comm_src}, {29'h0, e});
        chk({31'h0, accel_ff_en}, {31'h0, cur != 0});
        chk(inertia_current, 32'(cur));
        chk(inertia_accel, 32'(acc_val));
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        smask = '{0, 0, 0};
        amask = '{0, 0, 0};
        rdv = $urandom(10825);
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        check_sel();
        acc(1'b0, feedback_sel_pkg::SEL_INDEX, 8'h00, 32'h0, 32'h3, 1'b0);
        for (int s = 1; s <= 3; s++) begin
            acc(1'b0, feedback_sel_pkg::SEL_INDEX, 8'(s), 32'h0, 32'h0, 1'b0);
        end
        acc(1'b0, feedback_sel_pkg::MAP_INDEX, 8'h00, 32'h0, 32'h3, 1'b0);
        acc(1'b0, feedback_sel_pkg::MAP_INDEX, 8'h01, 32'h0, 32'h3380, 1'b0);
        acc(1'b0, feedback_sel_pkg::MAP_INDEX, 8'h02, 32'h0, 32'h3390, 1'b0);
        acc(1'b0, feedback_sel_pkg::MAP_INDEX, 8'h03, 32'h0, 32'h33a0, 1'b0);
        acc(1'b0, feedback_sel_pkg::INERTIA_INDEX, 8'h00, 32'h0, 32'h2, 1'b0);
        acc(1'b0, feedback_sel_pkg::INERTIA_INDEX, 8'h01, 32'h0, 32'h0, 1'b0);
        acc(1'b0, feedback_sel_pkg::INERTIA_INDEX, 8'h02, 32'h0, 32'h0, 1'b0);
        // refused accesses: unmapped places and read-only entries
        acc(1'b0, feedback_sel_pkg::SEL_INDEX, 8'h04, 32'h0, 32'h0, 1'b1);
        acc(1'b0, 16'h1234, 8'h00, 32'h0, 32'h0, 1'b1);
        acc(1'b1, feedback_sel_pkg::MAP_INDEX, 8'h01, 32'hffff, 32'h0, 1'b1);
        acc(1'b1, feedback_sel_pkg::SEL_INDEX, 8'h00, 32'h5, 32'h0, 1'b1);
        acc(1'b0, feedback_sel_pkg::MAP_INDEX, 8'h01, 32'h0, 32'h3380, 1'b0);
        acc(1'b0, feedback_sel_pkg::SEL_INDEX, 8'h00, 32'h0, 32'h3, 1'b0);
        // random masks, upper bits included, with random loop closure
        for (int n = 0; n < 40; n++) begin
            for (int s = 1; s <= 3; s++) begin
                acc(1'b1, feedback_sel_pkg::SEL_INDEX, 8'(s), $urandom % 256, 32'h0, 1'b0);
            end
            @(posedge clk_sys_i);
            submode_ctrl_i <= $urandom;
            check_sel();
            acc(1'b0, feedback_sel_pkg::SEL_INDEX, 8'(n % 3 + 1), 32'h0,
                32'(smask[n % 3 + 1]), 1'b0);
        end
        // writes while enabled are held back until operation enabled is left
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys_i);
            op_enabled_i <= 1'b1;
            check_sel();
            for (int s = 1; s <= 3; s++) begin
                acc(1'b1, feedback_sel_pkg::SEL_INDEX, 8'(s), $urandom % 256, 32'h0, 1'b0);
                acc(1'b0, feedback_sel_pkg::SEL_INDEX, 8'(s), 32'h0, 32'(smask[s]), 1'b0);
            end
            check_sel();
            @(posedge clk_sys_i);
            op_enabled_i <= 1'b0;
            check_sel();
        end
        // inertia factor gates acceleration feed forward
        master.calibrate(32'h0000_01f4, 32'h0000_00b6);
        cur = 32'h1f4;
        acc_val = 32'hb6;
        check_sel();
        acc(1'b0, feedback_sel_pkg::INERTIA_INDEX, 8'h01, 32'h0, 32'h1f4, 1'b0);
        acc(1'b0, feedback_sel_pkg::INERTIA_INDEX, 8'h02, 32'h0, 32'hb6, 1'b0);
        master.calibrate(32'h0, 32'h0000_0005);
        cur = 0;
        acc_val = 5;
        check_sel();
        give_verdict();
    end
endmodule
